/* rtf_fifo_core.sv */
`timescale 1ns/1ps
`default_nettype none
`include "rtf_defs.svh"
module rtf_fifo_core #(
	parameter int DEPTH = 64,
	parameter int AW = 6
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic spi_sck,
	input wire logic spi_nsel,
	input wire logic spi_sdi,
	output logic spi_sdo_ff,
	output logic irq_line_low_ff,
	output rtf_pkg::rtf_mode_t mode_ff,
	input wire logic tx_take,
	output logic [7:0] tx_byte_ff,
	output logic tx_byte_valid_ff,
	input wire logic [7:0] rx_byte,
	input wire logic rx_byte_valid
);
	// ----------------------------------------
	// Storage and state
	// ----------------------------------------
	logic [7:0] tx_mem [DEPTH];
	logic [7:0] rx_mem [DEPTH];
	logic [AW-1:0] tx_wp_ff, tx_rp_ff, rx_wp_ff, rx_rp_ff;
	logic [AW-1:0] nxt_tx_wp, nxt_tx_rp, nxt_rx_wp, nxt_rx_rp;
	logic [AW:0] tx_cnt_ff, rx_cnt_ff, nxt_tx_cnt, nxt_rx_cnt;
	logic sck_s1_ff, sck_s2_ff, sck_d_ff, nsel_s1_ff, nsel_s2_ff, sdi_s1_ff, sdi_s2_ff;
	logic [2:0] bit_ff, nxt_bit;
	logic first_ff, nxt_first, wr_ff, nxt_wr;
	logic [6:0] addr_ff, nxt_addr;
	logic [7:0] sr_in_ff, nxt_sr_in, sr_out_ff, nxt_sr_out;
	logic nxt_sdo, nxt_irq, nxt_txv;
	logic [7:0] nxt_txb;
	logic [7:0] stat1_ff, nxt_stat1, en1_ff, nxt_en1, en2_ff, nxt_en2;
	logic [7:0] op1_ff, nxt_op1, op2_ff, nxt_op2, pklen_ff, nxt_pklen, sent_ff, nxt_sent;
	logic [5:0] txaf_ff, nxt_txaf, txae_ff, nxt_txae, rxaf_ff, nxt_rxaf;
	logic txaf_lv_ff, txae_lv_ff, rxaf_lv_ff, nxt_txaf_lv, nxt_txae_lv, nxt_rxaf_lv;
	rtf_pkg::rtf_mode_t nxt_mode;
	logic tx_push, rx_push;
	logic [7:0] push_data;

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	// Two flops per pin, plus a third on sck for edge detect; only the second (and that third on sck) is looked at
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			sck_s1_ff <= 1'b0;
			sck_s2_ff <= 1'b0;
			sck_d_ff <= 1'b0;
			nsel_s1_ff <= 1'b1;
			nsel_s2_ff <= 1'b1;
			sdi_s1_ff <= 1'b0;
			sdi_s2_ff <= 1'b0;
		end
		else
		begin
			sck_s1_ff <= spi_sck;
			sck_s2_ff <= sck_s1_ff;
			sck_d_ff <= sck_s2_ff;
			nsel_s1_ff <= spi_nsel;
			nsel_s2_ff <= nsel_s1_ff;
			sdi_s1_ff <= spi_sdi;
			sdi_s2_ff <= sdi_s1_ff;
		end
	end

	// ----------------------------------------
	// Next-state logic
	// ----------------------------------------
	// One place for all cross effects: serial access, modem traffic, flags
	always_comb
	begin
		logic rise, fall, tx_pop, rx_pop, byte_done, stat_rd, ae_ev, af_ev, rf_ev, done;
		logic [7:0] rd, wbyte;
		rise = 1'b0;
		fall = 1'b0;
		tx_pop = 1'b0;
		rx_pop = 1'b0;
		byte_done = 1'b0;
		stat_rd = 1'b0;
		ae_ev = 1'b0;
		af_ev = 1'b0;
		rf_ev = 1'b0;
		done = 1'b0;
		rd = 8'h00;
		wbyte = 8'h00;
		nxt_bit = bit_ff;
		nxt_first = first_ff;
		nxt_wr = wr_ff;
		nxt_addr = addr_ff;
		nxt_sr_in = sr_in_ff;
		nxt_sr_out = sr_out_ff;
		nxt_sdo = spi_sdo_ff;
		nxt_stat1 = stat1_ff;
		nxt_en1 = en1_ff;
		nxt_en2 = en2_ff;
		nxt_op1 = op1_ff;
		nxt_op2 = op2_ff;
		nxt_pklen = pklen_ff;
		nxt_txaf = txaf_ff;
		nxt_txae = txae_ff;
		nxt_rxaf = rxaf_ff;
		nxt_mode = mode_ff;
		nxt_sent = sent_ff;
		nxt_txv = 1'b0;
		nxt_txb = tx_byte_ff;
		tx_push = 1'b0;
		rx_push = 1'b0;
		push_data = 8'h00;
		// Serial engine: sample on rising, shift out on falling edge
		if (nsel_s2_ff)
		begin
			nxt_bit = 3'h0;
			nxt_first = 1'b1;
		end
		else
		begin
			rise = sck_s2_ff & ~sck_d_ff;
			fall = ~sck_s2_ff & sck_d_ff;
		end
		if (fall)
		begin
			nxt_sdo = sr_out_ff[7];
			nxt_sr_out = {sr_out_ff[6:0], 1'b0};
		end
		if (rise)
		begin
			wbyte = {sr_in_ff[6:0], sdi_s2_ff};
			nxt_sr_in = wbyte;
			nxt_bit = bit_ff + 3'h1;
			byte_done = (bit_ff == 3'h7);
		end
		if (byte_done)
		begin
			if (first_ff)
			begin
				nxt_first = 1'b0;
				nxt_wr = wbyte[`RTF_B_WR];
				nxt_addr = wbyte[6:0];
			end
			if (!(first_ff ? wbyte[`RTF_B_WR] : wr_ff))
			begin
				// Read: load the byte for the next eight clocks
				case (first_ff ? wbyte[6:0] : addr_ff)
					`RTF_A_STAT1:
					begin
						// Status is cleared as it is handed out
						rd = stat1_ff;
						stat_rd = 1'b1;
					end
					`RTF_A_INTEN1: rd = en1_ff;
					`RTF_A_INTEN2: rd = en2_ff;
					`RTF_A_OPCTL1: rd = op1_ff;
					`RTF_A_OPCTL2: rd = op2_ff;
					`RTF_A_PKLEN: rd = pklen_ff;
					`RTF_A_TXAF: rd = {2'b00, txaf_ff};
					`RTF_A_TXAE: rd = {2'b00, txae_ff};
					`RTF_A_RXAF: rd = {2'b00, rxaf_ff};
					`RTF_A_FIFO:
					begin
						// Empty read gives zero and leaves pointers alone
						rx_pop = (rx_cnt_ff != '0);
						rd = rx_pop ? rx_mem[rx_rp_ff] : 8'h00;
					end
					default: rd = 8'h00;
				endcase
				nxt_sr_out = rd;
			end
			else if (!first_ff)
			begin
				case (addr_ff)
					`RTF_A_INTEN1: nxt_en1 = wbyte;
					`RTF_A_INTEN2: nxt_en2 = wbyte;
					`RTF_A_OPCTL1: nxt_op1 = wbyte;
					`RTF_A_OPCTL2: nxt_op2 = wbyte;
					`RTF_A_PKLEN: nxt_pklen = wbyte;
					`RTF_A_TXAF: nxt_txaf = wbyte[5:0];
					`RTF_A_TXAE: nxt_txae = wbyte[5:0];
					`RTF_A_RXAF: nxt_rxaf = wbyte[5:0];
					`RTF_A_FIFO:
					begin
						// Full FIFO drops the byte, stored data untouched
						tx_push = (tx_cnt_ff != DEPTH[AW:0]);
						push_data = wbyte;
					end
					default: ;
				endcase
			end
			// Burst walks the map but stays on the FIFO port; reads step past the loaded byte
			nxt_addr = ((first_ff ? wbyte[6:0] : addr_ff) == `RTF_A_FIFO) ? `RTF_A_FIFO
				: (first_ff ? wbyte[6:0] : addr_ff) + 7'h01;
			if (first_ff && wbyte[`RTF_B_WR])
				nxt_addr = wbyte[6:0];
		end
		// Mode control: host sets txon to start a packet
		if (mode_ff != rtf_pkg::RTF_TX && op1_ff[`RTF_B_TXON])
		begin
			nxt_mode = rtf_pkg::RTF_TX;
			nxt_sent = 8'h00;
		end
		else if (mode_ff == rtf_pkg::RTF_TX)
		begin
			if (tx_take && tx_cnt_ff != '0 && sent_ff != pklen_ff)
			begin
				tx_pop = 1'b1;
				nxt_txb = tx_mem[tx_rp_ff];
				nxt_txv = 1'b1;
				nxt_sent = sent_ff + 8'h01;
			end
			// Exactly pklen bytes, or exit on empty when asked
			done = (pklen_ff != 8'h00 && sent_ff == pklen_ff)
				|| (op2_ff[`RTF_B_EXITEMPTY] && tx_cnt_ff == '0);
			if (!op1_ff[`RTF_B_TXON] || done)
			begin
				// Return state picked by the ready bit of op control 1
				nxt_mode = op1_ff[`RTF_B_READY] ? rtf_pkg::RTF_READY : rtf_pkg::RTF_STANDBY;
				nxt_op1[`RTF_B_TXON] = 1'b0;
			end
		end
		if (rx_byte_valid && rx_cnt_ff != DEPTH[AW:0])
			rx_push = 1'b1;
		// Pointers; flush wins over traffic
		nxt_tx_wp = tx_wp_ff + AW'(tx_push);
		nxt_tx_rp = tx_rp_ff + AW'(tx_pop);
		nxt_tx_cnt = tx_cnt_ff + (AW+1)'(tx_push) - (AW+1)'(tx_pop);
		nxt_rx_wp = rx_wp_ff + AW'(rx_push);
		nxt_rx_rp = rx_rp_ff + AW'(rx_pop);
		nxt_rx_cnt = rx_cnt_ff + (AW+1)'(rx_push) - (AW+1)'(rx_pop);
		if (op2_ff[`RTF_B_FLTX])
		begin
			nxt_tx_wp = '0;
			nxt_tx_rp = '0;
			nxt_tx_cnt = '0;
			tx_push = 1'b0;
		end
		if (op2_ff[`RTF_B_FLRX])
		begin
			nxt_rx_wp = '0;
			nxt_rx_rp = '0;
			nxt_rx_cnt = '0;
			rx_push = 1'b0;
		end
		// Levels every clock; an event only on each entry
		nxt_txaf_lv = tx_cnt_ff > {1'b0, txaf_ff};
		nxt_txae_lv = tx_cnt_ff < {1'b0, txae_ff};
		nxt_rxaf_lv = rx_cnt_ff > {1'b0, rxaf_ff};
		af_ev = nxt_txaf_lv & ~txaf_lv_ff;
		ae_ev = nxt_txae_lv & ~txae_lv_ff;
		rf_ev = nxt_rxaf_lv & ~rxaf_lv_ff;
		// Read clears status; a same-cycle event still lands
		if (stat_rd)
			nxt_stat1 = 8'h00;
		nxt_stat1[`RTF_B_TXAF] = nxt_stat1[`RTF_B_TXAF] | af_ev;
		nxt_stat1[`RTF_B_TXAE] = nxt_stat1[`RTF_B_TXAE] | ae_ev;
		nxt_stat1[`RTF_B_RXAF] = nxt_stat1[`RTF_B_RXAF] | rf_ev;
		nxt_stat1[`RTF_B_PKSENT] = nxt_stat1[`RTF_B_PKSENT] | (done && mode_ff == rtf_pkg::RTF_TX);
		nxt_irq = ~|(nxt_stat1 & en1_ff);
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			tx_wp_ff <= '0;
			tx_rp_ff <= '0;
			rx_wp_ff <= '0;
			rx_rp_ff <= '0;
			tx_cnt_ff <= '0;
			rx_cnt_ff <= '0;
			bit_ff <= 3'h0;
			first_ff <= 1'b1;
			wr_ff <= 1'b0;
			addr_ff <= 7'h00;
			sr_in_ff <= 8'h00;
			sr_out_ff <= 8'h00;
			spi_sdo_ff <= 1'b0;
			irq_line_low_ff <= 1'b1;
			stat1_ff <= 8'h00;
			en1_ff <= 8'h00;
			en2_ff <= 8'h00;
			op1_ff <= `RTF_R_OPCTL1;
			op2_ff <= `RTF_R_OPCTL2;
			pklen_ff <= `RTF_R_PKLEN;
			txaf_ff <= `RTF_R_TXAF;
			txae_ff <= `RTF_R_TXAE;
			rxaf_ff <= `RTF_R_RXAF;
			txaf_lv_ff <= 1'b0;
			txae_lv_ff <= 1'b1;
			rxaf_lv_ff <= 1'b0;
			mode_ff <= rtf_pkg::RTF_READY;
			sent_ff <= 8'h00;
			tx_byte_ff <= 8'h00;
			tx_byte_valid_ff <= 1'b0;
		end
		else
		begin
			tx_wp_ff <= nxt_tx_wp;
			tx_rp_ff <= nxt_tx_rp;
			rx_wp_ff <= nxt_rx_wp;
			rx_rp_ff <= nxt_rx_rp;
			tx_cnt_ff <= nxt_tx_cnt;
			rx_cnt_ff <= nxt_rx_cnt;
			bit_ff <= nxt_bit;
			first_ff <= nxt_first;
			wr_ff <= nxt_wr;
			addr_ff <= nxt_addr;
			sr_in_ff <= nxt_sr_in;
			sr_out_ff <= nxt_sr_out;
			spi_sdo_ff <= nxt_sdo;
			irq_line_low_ff <= nxt_irq;
			stat1_ff <= nxt_stat1;
			en1_ff <= nxt_en1;
			en2_ff <= nxt_en2;
			op1_ff <= nxt_op1;
			op2_ff <= nxt_op2;
			pklen_ff <= nxt_pklen;
			txaf_ff <= nxt_txaf;
			txae_ff <= nxt_txae;
			rxaf_ff <= nxt_rxaf;
			txaf_lv_ff <= nxt_txaf_lv;
			txae_lv_ff <= nxt_txae_lv;
			rxaf_lv_ff <= nxt_rxaf_lv;
			mode_ff <= nxt_mode;
			sent_ff <= nxt_sent;
			tx_byte_ff <= nxt_txb;
			tx_byte_valid_ff <= nxt_txv;
		end
	end

	// Memory arrays carry no reset; pointers make them safe
	// Separate data paths, so a host push and a modem push can share a cycle
	always_ff @(posedge clk)
	begin
		if (tx_push)
			tx_mem[tx_wp_ff] <= push_data;
		if (rx_push)
			rx_mem[rx_wp_ff] <= rx_byte;
	end
endmodule : rtf_fifo_core
`default_nettype wire

/* rtf_defs.svh */
`ifndef RTF_DEFS_SVH
`define RTF_DEFS_SVH
// Register addresses, 7 bits on the serial port
`define RTF_A_STAT1 7'h03
`define RTF_A_INTEN1 7'h05
`define RTF_A_INTEN2 7'h06
`define RTF_A_OPCTL1 7'h07
`define RTF_A_OPCTL2 7'h08
`define RTF_A_PKLEN 7'h3e
`define RTF_A_TXAF 7'h7c
`define RTF_A_TXAE 7'h7d
`define RTF_A_RXAF 7'h7e
`define RTF_A_FIFO 7'h7f
// Reset values
`define RTF_R_OPCTL1 8'h01
`define RTF_R_OPCTL2 8'h00
`define RTF_R_TXAF 6'h37
`define RTF_R_TXAE 6'h04
`define RTF_R_RXAF 6'h37
`define RTF_R_PKLEN 8'h00
// Bit positions in status / enable 1
`define RTF_B_TXAF 6
`define RTF_B_TXAE 5
`define RTF_B_RXAF 4
`define RTF_B_PKSENT 2
// Bit positions in op control 1 / 2
`define RTF_B_READY 0
`define RTF_B_TXON 3
`define RTF_B_FLTX 0
`define RTF_B_FLRX 1
`define RTF_B_EXITEMPTY 3
// Serial command: top bit set means write
`define RTF_B_WR 7
`endif

/* rtf_pkg.sv */
package rtf_pkg;
	typedef enum logic [1:0] {RTF_STANDBY, RTF_READY, RTF_TX} rtf_mode_t;
endpackage : rtf_pkg

/* rtf_fifo_core_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module rtf_fifo_core_sva (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic spi_sck,
	input wire logic spi_nsel,
	input wire logic spi_sdo_ff,
	input wire logic irq_line_low_ff,
	input wire rtf_pkg::rtf_mode_t mode_ff,
	input wire logic tx_take,
	input wire logic [7:0] tx_byte_ff,
	input wire logic tx_byte_valid_ff
);
	// ----------------------------
	// Port relations
	// ----------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	// Pop request seen while transmitting
	sequence s_take_tx;
		tx_take && mode_ff == rtf_pkg::RTF_TX;
	endsequence
	// Serial clock without a falling edge
	sequence s_quiet_sck;
		!$fell(spi_sck) [*6];
	endsequence
	a_reset_outputs: assert property (disable iff (1'b0)
		!rst_n |=> irq_line_low_ff && !tx_byte_valid_ff && mode_ff == rtf_pkg::RTF_READY)
		else $error("outputs not at reset values");
	a_valid_cause: assert property (
		tx_byte_valid_ff |-> $past(tx_take && mode_ff == rtf_pkg::RTF_TX))
		else $error("byte valid without accepted take");
	a_pop_blocked: assert property (
		tx_take && mode_ff != rtf_pkg::RTF_TX |=> !tx_byte_valid_ff)
		else $error("pop outside transmit");
	a_byte_hold: assert property (
		!tx_byte_valid_ff |-> $stable(tx_byte_ff))
		else $error("tx byte changed without pop");
	a_sdo_hold: assert property (
		s_quiet_sck |=> $stable(spi_sdo_ff))
		else $error("sdo moved without sck fall");
	a_irq_release: assert property (
		$rose(irq_line_low_ff) |-> !$past(spi_nsel, 2))
		else $error("irq released without host access");
	a_tx_entry: assert property (
		$rose(mode_ff == rtf_pkg::RTF_TX) |-> !$past(spi_nsel, 2))
		else $error("transmit entered without host command");
	a_tx_exit: assert property (
		$fell(mode_ff == rtf_pkg::RTF_TX) |->
		$past(tx_byte_valid_ff) || $past(tx_byte_valid_ff, 2) || !$past(spi_nsel, 2))
		else $error("transmit left without cause");
	c_pop: cover property (s_take_tx ##1 tx_byte_valid_ff);
endmodule : rtf_fifo_core_sva
bind rtf_fifo_core rtf_fifo_core_sva u_sva (.clk(clk), .rst_n(rst_n), .spi_sck(spi_sck),
	.spi_nsel(spi_nsel), .spi_sdo_ff(spi_sdo_ff), .irq_line_low_ff(irq_line_low_ff),
	.mode_ff(mode_ff), .tx_take(tx_take), .tx_byte_ff(tx_byte_ff),
	.tx_byte_valid_ff(tx_byte_valid_ff));
`default_nettype wire

/* rtf_host.sv */
`timescale 1ns/1ps
`default_nettype none
module rtf_host (
	output logic spi_sck,
	output logic spi_nsel,
	output logic spi_sdi,
	input wire logic spi_sdo
);
	localparam realtime HALF = 62.5;
	logic [7:0] junk;
	// Idle pins; the serial clock stands low outside frames
	initial
	begin
		spi_sck = 1'b0;
		spi_nsel = 1'b1;
		spi_sdi = 1'b0;
	end
	task sel;
		spi_nsel = 1'b0;
		#HALF;
	endtask : sel
	// MSB first, read bit taken at each rising edge
	task shift(input logic [7:0] w, output logic [7:0] r);
		for (int k = 7; k >= 0; k--)
		begin
			spi_sdi = w[k];
			#HALF spi_sck = 1'b1;
			r = {r[6:0], spi_sdo};
			#HALF spi_sck = 1'b0;
		end
	endtask : shift
	// Released data line flips so a stale bit is never mistaken for data
	task desel;
		#HALF spi_nsel = 1'b1;
		spi_sdi = ~spi_sdi;
		#(2 * HALF);
	endtask : desel
	task wr(input logic [6:0] a, input logic [7:0] d);
		sel;
		shift({1'b1, a}, junk);
		shift(d, junk);
		desel;
	endtask : wr
	task rd(input logic [6:0] a, output logic [7:0] d);
		sel;
		shift({1'b0, a}, d);
		shift(8'h00, d);
		desel;
	endtask : rd
endmodule : rtf_host
`default_nettype wire

/* rtf_fifo_core_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "rtf_defs.svh"
module rtf_fifo_core_tb;
	logic clk, rst_n, tx_take, rx_byte_valid, spi_sck, spi_nsel, spi_sdi;
	logic spi_sdo_ff, irq_line_low_ff, tx_byte_valid_ff;
	logic [7:0] tx_byte_ff, rx_byte, r;
	rtf_pkg::rtf_mode_t mode_ff;
	int err_total, n_tests, i;
	logic [6:0] ra [8] = '{7'h7c, 7'h7d, 7'h7e, 7'h08, 7'h07, 7'h3e, 7'h03, 7'h20};
	logic [7:0] rv [8] = '{8'h37, 8'h04, 8'h37, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00};
	rtf_fifo_core dut (.clk(clk), .rst_n(rst_n), .spi_sck(spi_sck), .spi_nsel(spi_nsel),
		.spi_sdi(spi_sdi), .spi_sdo_ff(spi_sdo_ff), .irq_line_low_ff(irq_line_low_ff),
		.mode_ff(mode_ff), .tx_take(tx_take), .tx_byte_ff(tx_byte_ff),
		.tx_byte_valid_ff(tx_byte_valid_ff), .rx_byte(rx_byte), .rx_byte_valid(rx_byte_valid));
	rtf_host host (.spi_sck(spi_sck), .spi_nsel(spi_nsel), .spi_sdi(spi_sdi),
		.spi_sdo(spi_sdo_ff));
	// ----------------------------
	// Clock, checks and modem side
	// ----------------------------
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
			err_total++;
		end
	endtask : chk
	task finish_test;
		$display("checks %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : finish_test
	task settle(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : settle
	task push(input logic [7:0] b);
		@(posedge clk);
		rx_byte <= b;
		rx_byte_valid <= 1'b1;
		@(posedge clk);
		rx_byte_valid <= 1'b0;
	endtask : push
	// Pop pulse, then look at the answer once that edge has landed
	task take(input logic v, input logic [7:0] b);
		@(posedge clk);
		tx_take <= 1'b1;
		@(posedge clk);
		tx_take <= 1'b0;
		#1;
		chk("txv", tx_byte_valid_ff, v);
		if (v)
			chk("txb", tx_byte_ff, b);
	endtask : take
	task fill(input logic [7:0] b, input int n);
		host.sel;
		host.shift({1'b1, `RTF_A_FIFO}, r);
		for (int k = 0; k < n; k++)
			host.shift(b + k[7:0], r);
		host.desel;
	endtask : fill
	// Hang guard
	initial
	begin
		repeat (100000) @(posedge clk);
		err_total++;
		finish_test;
	end
	// ----------------------------
	// Scenarios
	// ----------------------------
	initial
	begin
		rst_n = 1'b0;
		tx_take = 1'b0;
		rx_byte_valid = 1'b0;
		rx_byte = 8'h00;
		err_total = 0;
		n_tests = 0;
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		settle(5);
		for (i = 0; i < 8; i++)
		begin
			host.rd(ra[i], r);
			chk("reset", r, rv[i]);
		end
		$display("test regs done");
		host.wr(`RTF_A_INTEN1, 8'h10);
		host.wr(`RTF_A_RXAF, 8'h02);
		push(8'h11);
		push(8'h22);
		settle(3);
		chk("irq2", irq_line_low_ff, 1'b1);
		push(8'h33);
		settle(3);
		chk("irq3", irq_line_low_ff, 1'b0);
		host.rd(`RTF_A_STAT1, r);
		chk("stat", r, 8'h10);
		chk("irqc", irq_line_low_ff, 1'b1);
		// Host drains what the modem brought in
		host.sel;
		host.shift({1'b0, `RTF_A_FIFO}, r);
		for (i = 1; i < 4; i++)
		begin
			host.shift(8'h00, r);
			chk("rxd", r, 8'h11 * i[7:0]);
		end
		host.desel;
		host.rd(`RTF_A_FIFO, r);
		chk("rxe", r, 8'h00);
		host.wr(`RTF_A_INTEN1, 8'h00);
		for (i = 0; i < 3; i++)
			push(8'h44);
		settle(3);
		chk("irqm", irq_line_low_ff, 1'b1);
		host.rd(`RTF_A_STAT1, r);
		chk("statm", r, 8'h10);
		host.wr(`RTF_A_OPCTL2, 8'h02);
		host.wr(`RTF_A_OPCTL2, 8'h00);
		host.rd(`RTF_A_FIFO, r);
		chk("rxfl", r, 8'h00);
		$display("test rx done");
		host.wr(`RTF_A_TXAF, 8'h02);
		fill(8'ha1, 4);
		host.rd(`RTF_A_STAT1, r);
		chk("txaf", r, 8'h40);
		host.wr(`RTF_A_PKLEN, 8'h03);
		host.wr(`RTF_A_OPCTL1, 8'h09);
		for (i = 0; i < 3; i++)
			take(1'b1, 8'ha1 + i[7:0]);
		settle(2);
		chk("mode", {6'h00, mode_ff}, {6'h00, rtf_pkg::RTF_READY});
		take(1'b0, 8'h00);
		host.rd(`RTF_A_STAT1, r);
		chk("txae", r, 8'h24);
		host.wr(`RTF_A_OPCTL2, 8'h08);
		host.wr(`RTF_A_OPCTL1, 8'h08);
		take(1'b1, 8'ha4);
		settle(2);
		chk("exit", mode_ff == rtf_pkg::RTF_TX, 1'b0);
		host.wr(`RTF_A_OPCTL2, 8'h00);
		$display("test tx done");
		fill(8'hee, 2);
		host.wr(`RTF_A_OPCTL2, 8'h01);
		host.wr(`RTF_A_OPCTL2, 8'h00);
		fill(8'h00, 65);
		host.wr(`RTF_A_PKLEN, 8'h41);
		host.wr(`RTF_A_OPCTL1, 8'h09);
		for (i = 0; i < 65; i++)
			take(i < 64, i[7:0]);
		host.wr(`RTF_A_OPCTL1, 8'h01);
		settle(2);
		chk("leave", mode_ff == rtf_pkg::RTF_TX, 1'b0);
		$display("test full done");
		finish_test;
	end
endmodule : rtf_fifo_core_tb
`default_nettype wire
